//--- src/filter_cfg_if.sv
// Purpose: Carries the video filter setup from the registers to the filter.
// Assumes: Single clock domain.
// Notes:   No clocking block.
interface filter_cfg_if;
  logic any_long_type_pass;
  logic type_match_enable;
  logic yuv10_pass_enable;
  logic frame_valid_invert;
  logic line_valid_invert;
  vfbs_pkg::data_type_t type_match_value;
  modport src (output any_long_type_pass, type_match_enable,
    yuv10_pass_enable, frame_valid_invert, line_valid_invert,
    type_match_value);
  modport dst (input any_long_type_pass, type_match_enable,
    yuv10_pass_enable, frame_valid_invert, line_valid_invert,
    type_match_value);
endinterface

//--- src/packet_type_filter.sv
// Purpose: Pass decision per packet data type, sync polarity inversion.
// Assumes: Packet type, valid and syncs are synchronous to pclk.
// Notes:   Decision and syncs are registered, one cycle of latency.
`include "vfbs_map.svh"
module packet_type_filter
  import vfbs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  filter_cfg_if.dst cfg,
  input wire logic fast_video_mode,
  input wire logic pkt_valid,
  input wire vfbs_pkg::data_type_t pkt_type,
  input wire logic frame_valid_in,
  input wire logic line_valid_in,
  output logic pkt_pass_ff,
  output logic pkt_done_ff,
  output logic frame_valid_ff,
  output logic line_valid_ff
);
  logic is_long;
  logic match_long;
  logic is_yuv10;
  logic nxt_pass;

  always_comb
  begin
    is_long = pkt_type[5] | pkt_type[4];
    match_long = cfg.type_match_value[5] | cfg.type_match_value[4];
    is_yuv10 = (pkt_type == `DT_YUV10_A) || (pkt_type == `DT_YUV10_B) ||
      (pkt_type == `DT_YUV10_C);
    nxt_pass = 1'b0;
    if (cfg.any_long_type_pass && is_long)
      nxt_pass = 1'b1;
    // Match ignores the 75M/100M mode; short codes never match
    if (cfg.type_match_enable && match_long &&
        pkt_type == cfg.type_match_value)
      nxt_pass = 1'b1;
    if (cfg.yuv10_pass_enable && fast_video_mode && is_yuv10)
      nxt_pass = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pkt_pass_ff <= 1'b0;
      pkt_done_ff <= 1'b0;
    end
    else
    begin
      pkt_pass_ff <= pkt_valid & nxt_pass;
      pkt_done_ff <= pkt_valid;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      frame_valid_ff <= 1'b0;
      line_valid_ff <= 1'b0;
    end
    else
    begin
      frame_valid_ff <= frame_valid_in ^ cfg.frame_valid_invert;
      line_valid_ff <= line_valid_in ^ cfg.line_valid_invert;
    end
  end
endmodule

//--- src/parity_error_injector.sv
// Purpose: Emits a burst of forward-channel parity error pulses.
// Assumes: Trigger is a one-cycle pulse.
// Notes:   A trigger during a burst restarts it with the new count.
module parity_error_injector (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic trigger,
  input wire logic [6:0] count,
  output logic error_pulse_ff,
  output logic busy
);
  logic [6:0] remain_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      remain_ff <= 7'h00;
    else if (trigger)
      remain_ff <= count;
    else if (remain_ff != 7'h00)
      remain_ff <= remain_ff - 7'h01;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      error_pulse_ff <= 1'b0;
    else
      error_pulse_ff <= (remain_ff != 7'h00);
  end

  assign busy = (remain_ff != 7'h00) | error_pulse_ff;
endmodule

//--- src/vfbs_map.svh
// Purpose: Offsets, field positions, reset values and counts for the
//          video filter, self-test and sensor register bank.
// Assumes: Register offsets are word indices; byte address is four times.
// Notes:   Definitions only.
`ifndef VFBS_MAP_SVH
`define VFBS_MAP_SVH

// ****************************************************************
// Register indices
// ****************************************************************
`define IDX_FILTER_CFG 10'h010
`define IDX_MATCH_VAL 10'h011
`define IDX_RSVD_A 10'h012
`define IDX_ERR_FORCE 10'h013
`define IDX_TEST_CTRL 10'h014
`define IDX_VGAIN 10'h015
`define IDX_RSVD_B 10'h016
`define IDX_MON_CTRL0 10'h017
`define IDX_MON_CTRL1 10'h018

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_FILTER_CFG 8'h00
`define RST_MATCH_VAL 8'h00
`define RST_RSVD_A 8'h00
`define RST_ERR_COUNT 7'h00
`define RST_TEST_CTRL 8'h00
`define RST_VGAIN 8'h20
`define RST_RSVD_B 8'h18
`define RST_MON_CTRL0 8'h3c
`define RST_MON_CTRL1 8'h80

// ****************************************************************
// Field positions
// ****************************************************************
`define FB_ANY_LONG 4
`define FB_MATCH_EN 3
`define FB_YUV_EN 2
`define FB_FV_INV 1
`define FB_LV_INV 0
`define FB_FORCE_TRIG 7
`define FB_LOCAL_TEST 3
`define FB_REMOTE_TEST 0
`define FB_GAIN_APPLY 7

// ****************************************************************
// Data type codes and gain figures
// ****************************************************************
`define DT_YUV10_A 6'h19
`define DT_YUV10_B 6'h1d
`define DT_YUV10_C 6'h1f
`define GAIN_NUMERATOR 8'h80
`define GAIN_SATURATE 8'hff

`endif

//--- src/vfbs_pkg.sv
// Purpose: Types shared by the register bank and its helpers.
// Assumes: Nothing beyond the map header.
// Notes:   Holds no numbers of its own.
package vfbs_pkg;
  typedef enum logic [1:0] {clk_external, clk_int_50m, clk_int_25m}
    self_test_clk_t;
  typedef logic [5:0] data_type_t;
endpackage

//--- src/video_filter_built_in_self_test_sensor_regs.sv
// Purpose: APB register bank for the parallel video filter, built-in
//          self test with parity error forcing, and sensor setup.
// Assumes: APB with 32-bit data; registers hold 8 bits in the low lane.
// Notes:   No wait states on any transfer; read data are registered.
//
// Overview of operation
// - Any-long-type bit passes every packet with a long data type.
// - Match-enable bit compares packet types with the stored match value.
// - While matching is on, writes to the match value are ignored.
// - YUV bit in fast mode passes types 0x19, 0x1d and 0x1f.
// - Bit 1 inverts frame valid, bit 0 inverts line valid.
// - Matching types pass whichever video speed mode is selected.
// - Only a long match value, bit 5 or 4 set, can match.
// - Writing the self-clearing force bit outside self test injects the programmed errors.
// - Entering self test injects the programmed errors automatically.
// - Seven-bit count sets errors per forcing event, reset zero.
// - Local self-test enable bit puts the device in self test.
// - Clock select: 00 external, 01 internal 50 MHz, 1X 25 MHz.
// - Bit 0 enables the video-path compatible self-test mode.
// - Nonzero upper control field enables forcing, zero disables it.
// - Voltage gain equals 128 divided by the seven-bit field.
// - Sensor enable field: 00 off, 11 on, resets enabled.
// - GPIO sense select: none, GPIO0, GPIO1 or both pins.
// - Gain-apply bit applies the sensor gain, resets to one.
//
// Chosen here: the APB slave port.
`include "vfbs_map.svh"
module video_filter_built_in_self_test_sensor_regs
  import vfbs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fast_video_mode,
  input wire logic pkt_valid,
  input wire vfbs_pkg::data_type_t pkt_type,
  input wire logic frame_valid_in,
  input wire logic line_valid_in,
  output logic pkt_pass,
  output logic pkt_done,
  output logic frame_valid_out,
  output logic line_valid_out,
  output logic self_test_active,
  output logic remote_self_test_enable,
  output vfbs_pkg::self_test_clk_t self_test_clock_select,
  output logic forward_error_force_enable,
  output logic parity_error_inject,
  output logic parity_inject_busy,
  output logic [6:0] voltage_gain_divisor,
  output logic [7:0] voltage_gain_ratio,
  output logic sensor_gain_apply,
  output logic sensors_enabled,
  output logic [1:0] gpio_sense_select
);
  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [7:0] filter_cfg_ff;
  logic [7:0] match_val_ff;
  logic [7:0] rsvd_a_ff;
  logic [6:0] err_count_ff;
  logic [7:0] test_ctrl_ff;
  logic [7:0] vgain_ff;
  logic [7:0] rsvd_b_ff;
  logic [7:0] mon_ctrl0_ff;
  logic [7:0] mon_ctrl1_ff;
  logic [31:0] prdata_ff;
  logic slverr_ff;
  logic test_active_ff;
  logic force_nz_ff;
  logic [7:0] gain_ratio_ff;

  logic [9:0] idx;
  logic mapped;
  logic wr_en;
  logic [7:0] wbyte;
  logic [7:0] nxt_rdata;
  logic force_write;
  logic test_entry;
  logic force_rise;
  logic inject_trigger;
  logic [7:0] nxt_gain_ratio;

  filter_cfg_if cfg_bus ();

  // ****************************************************************
  // APB decode
  // ****************************************************************
  always_comb
  begin
    idx = paddr[11:2];
    mapped = (paddr[1:0] == 2'b00) &&
      (idx >= `IDX_FILTER_CFG) && (idx <= `IDX_MON_CTRL1);
  end

  // Access phase always completes; setup already prepared the answer
  assign pready = psel & penable;
  assign pslverr = psel & penable & slverr_ff;
  assign prdata = prdata_ff;
  assign wr_en = psel & penable & pwrite & mapped & pstrb[0];
  assign wbyte = pwdata[7:0];

  always_comb
  begin
    nxt_rdata = 8'h00;
    unique case (idx)
      `IDX_FILTER_CFG: nxt_rdata = filter_cfg_ff;
      `IDX_MATCH_VAL: nxt_rdata = match_val_ff;
      `IDX_RSVD_A: nxt_rdata = rsvd_a_ff;
      `IDX_ERR_FORCE: nxt_rdata = {1'b0, err_count_ff};
      `IDX_TEST_CTRL: nxt_rdata = test_ctrl_ff;
      `IDX_VGAIN: nxt_rdata = vgain_ff;
      `IDX_RSVD_B: nxt_rdata = rsvd_b_ff;
      `IDX_MON_CTRL0: nxt_rdata = mon_ctrl0_ff;
      `IDX_MON_CTRL1: nxt_rdata = mon_ctrl1_ff;
      default: nxt_rdata = 8'h00;
    endcase
    if (!mapped)
      nxt_rdata = 8'h00;
  end

  // Read data and error are latched in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_ff <= 32'h0000_0000;
      slverr_ff <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata_ff <= {24'h00_0000, nxt_rdata};
      slverr_ff <= ~mapped;
    end
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  // Reserved fields are kept as written; software keeps their defaults
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      filter_cfg_ff <= `RST_FILTER_CFG;
      rsvd_a_ff <= `RST_RSVD_A;
      rsvd_b_ff <= `RST_RSVD_B;
    end
    else if (wr_en)
    begin
      if (idx == `IDX_FILTER_CFG)
        filter_cfg_ff <= wbyte;
      if (idx == `IDX_RSVD_A)
        rsvd_a_ff <= wbyte;
      if (idx == `IDX_RSVD_B)
        rsvd_b_ff <= wbyte;
    end
  end

  // Blocking uses the enable as stored before this write lands
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      match_val_ff <= `RST_MATCH_VAL;
    else if (wr_en && idx == `IDX_MATCH_VAL &&
             !filter_cfg_ff[`FB_MATCH_EN])
      match_val_ff <= wbyte;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      err_count_ff <= `RST_ERR_COUNT;
      test_ctrl_ff <= `RST_TEST_CTRL;
    end
    else if (wr_en)
    begin
      if (idx == `IDX_ERR_FORCE)
        err_count_ff <= wbyte[6:0];
      if (idx == `IDX_TEST_CTRL)
        test_ctrl_ff <= wbyte;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vgain_ff <= `RST_VGAIN;
      mon_ctrl0_ff <= `RST_MON_CTRL0;
      mon_ctrl1_ff <= `RST_MON_CTRL1;
    end
    else if (wr_en)
    begin
      if (idx == `IDX_VGAIN)
        vgain_ff <= wbyte;
      if (idx == `IDX_MON_CTRL0)
        mon_ctrl0_ff <= wbyte;
      if (idx == `IDX_MON_CTRL1)
        mon_ctrl1_ff <= wbyte;
    end
  end

  // ****************************************************************
  // Video filter
  // ****************************************************************
  assign cfg_bus.any_long_type_pass = filter_cfg_ff[`FB_ANY_LONG];
  assign cfg_bus.type_match_enable = filter_cfg_ff[`FB_MATCH_EN];
  assign cfg_bus.yuv10_pass_enable = filter_cfg_ff[`FB_YUV_EN];
  assign cfg_bus.frame_valid_invert = filter_cfg_ff[`FB_FV_INV];
  assign cfg_bus.line_valid_invert = filter_cfg_ff[`FB_LV_INV];
  assign cfg_bus.type_match_value = match_val_ff[5:0];

  packet_type_filter u_filter (
    .pclk(pclk),
    .presetn(presetn),
    .cfg(cfg_bus.dst),
    .fast_video_mode(fast_video_mode),
    .pkt_valid(pkt_valid),
    .pkt_type(pkt_type),
    .frame_valid_in(frame_valid_in),
    .line_valid_in(line_valid_in),
    .pkt_pass_ff(pkt_pass),
    .pkt_done_ff(pkt_done),
    .frame_valid_ff(frame_valid_out),
    .line_valid_ff(line_valid_out)
  );

  // ****************************************************************
  // Self test and error forcing
  // ****************************************************************
  assign self_test_active = test_ctrl_ff[`FB_LOCAL_TEST] |
    test_ctrl_ff[`FB_REMOTE_TEST];
  assign remote_self_test_enable = test_ctrl_ff[`FB_REMOTE_TEST];
  assign forward_error_force_enable = |test_ctrl_ff[7:4];

  always_comb
  begin
    unique case (test_ctrl_ff[2:1])
      2'b00: self_test_clock_select = clk_external;
      2'b01: self_test_clock_select = clk_int_50m;
      default: self_test_clock_select = clk_int_25m;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      test_active_ff <= 1'b0;
      force_nz_ff <= 1'b0;
    end
    else
    begin
      test_active_ff <= self_test_active;
      force_nz_ff <= forward_error_force_enable;
    end
  end

  // The trigger bit is never stored, so it reads back as zero
  assign force_write = wr_en && idx == `IDX_ERR_FORCE &&
    wbyte[`FB_FORCE_TRIG] && !self_test_active;
  assign test_entry = self_test_active & ~test_active_ff;
  assign force_rise = forward_error_force_enable & ~force_nz_ff;
  assign inject_trigger = force_write | test_entry | force_rise;

  // A force write carries its own count, which lands the same edge
  parity_error_injector u_inject (
    .pclk(pclk),
    .presetn(presetn),
    .trigger(inject_trigger),
    .count(force_write ? wbyte[6:0] : err_count_ff),
    .error_pulse_ff(parity_error_inject),
    .busy(parity_inject_busy)
  );

  // ****************************************************************
  // Sensors
  // ****************************************************************
  assign voltage_gain_divisor = vgain_ff[6:0];
  assign sensor_gain_apply = mon_ctrl1_ff[`FB_GAIN_APPLY];
  assign sensors_enabled = (mon_ctrl0_ff[3:2] == 2'b11);
  assign gpio_sense_select = mon_ctrl0_ff[1:0];
  assign voltage_gain_ratio = gain_ratio_ff;

  // A zero divisor has no gain; it saturates rather than divide by zero
  always_comb
  begin
    if (vgain_ff[6:0] == 7'h00)
      nxt_gain_ratio = `GAIN_SATURATE;
    else
      nxt_gain_ratio = `GAIN_NUMERATOR / {1'b0, vgain_ff[6:0]};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gain_ratio_ff <= 8'h04;
    else
      gain_ratio_ff <= nxt_gain_ratio;
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic [7:0] tally_ff;
  logic [6:0] loaded_ff;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tally_ff <= 8'h00;
      loaded_ff <= 7'h00;
    end
    else if (inject_trigger)
    begin
      tally_ff <= 8'h00;
      loaded_ff <= force_write ? wbyte[6:0] : err_count_ff;
    end
    else if (parity_error_inject)
      tally_ff <= tally_ff + 8'h01;
  end

  sequence s_force_write;
    force_write && wbyte[6:0] != 7'h00;
  endsequence
  sequence s_burst_start;
    ##1 parity_inject_busy ##1 parity_error_inject;
  endsequence

  a_match_write_block: assert property (
    wr_en && idx == `IDX_MATCH_VAL && filter_cfg_ff[`FB_MATCH_EN]
    |=> $stable(match_val_ff))
    else $error("match value changed while matching enabled");
  a_any_long_pass: assert property (
    pkt_valid && filter_cfg_ff[`FB_ANY_LONG] && (pkt_type[5] | pkt_type[4])
    |=> pkt_pass)
    else $error("long packet not passed");
  a_match_type_pass: assert property (
    pkt_valid && filter_cfg_ff[`FB_MATCH_EN] && match_val_ff[5:4] != 2'b00
    && pkt_type == match_val_ff[5:0] |=> pkt_pass)
    else $error("matching packet not passed");
  a_short_no_match: assert property (
    pkt_valid && filter_cfg_ff[`FB_ANY_LONG:`FB_YUV_EN] == 3'b010 &&
    match_val_ff[5:4] == 2'b00 |=> !pkt_pass)
    else $error("short match value produced a pass");
  a_yuv_fast_pass: assert property (
    pkt_valid && filter_cfg_ff[`FB_YUV_EN] && fast_video_mode &&
    pkt_type == `DT_YUV10_B |=> pkt_pass)
    else $error("yuv packet not passed in fast mode");
  // The edge that releases reset still loads zeros, so skip it
  a_sync_invert: assert property (
    $past(presetn) |-> frame_valid_out == ($past(frame_valid_in) ^
    $past(filter_cfg_ff[`FB_FV_INV])) && line_valid_out ==
    ($past(line_valid_in) ^ $past(filter_cfg_ff[`FB_LV_INV])))
    else $error("sync polarity wrong");
  a_force_burst: assert property (
    s_force_write |-> s_burst_start)
    else $error("force write did not start a burst");
  a_entry_burst: assert property (
    test_entry && err_count_ff != 7'h00 |-> s_burst_start)
    else $error("self-test entry did not start a burst");
  a_burst_length: assert property (
    $fell(parity_inject_busy) && !$past(inject_trigger) |->
    tally_ff == {1'b0, loaded_ff})
    else $error("wrong number of forced errors");
  a_trigger_reads_zero: assert property (
    psel && !penable && !pwrite && idx == `IDX_ERR_FORCE && mapped
    |=> prdata[7] == 1'b0)
    else $error("force trigger read back as one");
  a_clock_select: assert property (
    test_ctrl_ff[2] |-> self_test_clock_select == clk_int_25m)
    else $error("clock select decode wrong");
  a_sensor_enable: assert property (
    mon_ctrl0_ff[3:2] == 2'b00 |-> !sensors_enabled)
    else $error("sensors on while disabled");
endmodule

//--- test/tb_video_filter_built_in_self_test_sensor_regs.sv
// Purpose: Self-checking bench for the video filter, self-test and
//          sensor register bank, driven over APB.
// Assumes: One clock, APB master waits for pready with no fixed latency.
// Notes:   No partner model; packet and sync inputs come from the bench.
module tb_video_filter_built_in_self_test_sensor_regs;
  timeunit 1ns;
  timeprecision 100ps;
  import vfbs_pkg::*;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic pready, pslverr, fast_video_mode, pkt_valid;
  data_type_t pkt_type;
  logic frame_valid_in, line_valid_in, pkt_pass, pkt_done;
  logic frame_valid_out, line_valid_out, self_test_active;
  logic remote_self_test_enable, forward_error_force_enable;
  self_test_clk_t self_test_clock_select;
  logic parity_error_inject, parity_inject_busy;
  logic [6:0] voltage_gain_divisor;
  logic [7:0] voltage_gain_ratio;
  logic sensor_gain_apply, sensors_enabled;
  logic [1:0] gpio_sense_select;
  int mismatches = 0;
  int tests_run = 0;
  logic [7:0] rq;
  logic re;
  logic [7:0] rst_tab [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20,
    8'h18, 8'h3c, 8'h80};

  video_filter_built_in_self_test_sensor_regs video_filter_built_in_self_test_sensor_regs_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fast_video_mode(fast_video_mode), .pkt_valid(pkt_valid),
    .pkt_type(pkt_type), .frame_valid_in(frame_valid_in),
    .line_valid_in(line_valid_in), .pkt_pass(pkt_pass),
    .pkt_done(pkt_done), .frame_valid_out(frame_valid_out),
    .line_valid_out(line_valid_out), .self_test_active(self_test_active),
    .remote_self_test_enable(remote_self_test_enable),
    .self_test_clock_select(self_test_clock_select),
    .forward_error_force_enable(forward_error_force_enable),
    .parity_error_inject(parity_error_inject),
    .parity_inject_busy(parity_inject_busy),
    .voltage_gain_divisor(voltage_gain_divisor),
    .voltage_gain_ratio(voltage_gain_ratio),
    .sensor_gain_apply(sensor_gain_apply),
    .sensors_enabled(sensors_enabled),
    .gpio_sense_select(gpio_sense_select));

  initial pclk = 1'b0;
  always #4 pclk = ~pclk;

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [9:0] idx,
                     input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rq = prdata[7:0];
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    chk(rq, e);
    chk(re, 1'b0);
  endtask

  // Lets the registered outputs of a write settle before sampling
  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask

  task automatic pkt(input data_type_t t, input logic e);
    @(posedge pclk);
    pkt_valid <= 1'b1;
    pkt_type <= t;
    @(posedge pclk);
    pkt_valid <= 1'b0;
    #1;
    chk(pkt_done, 1'b1);
    chk(pkt_pass, e);
  endtask

  // Counts inject pulses in a window longer than any burst used here
  task automatic pulses(input int e);
    int n;
    n = 0;
    repeat (16)
    begin
      @(posedge pclk);
      #1;
      if (parity_error_inject === 1'b1)
        n++;
    end
    chk(n, e);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, pkt_valid, fast_video_mode} = 5'h00;
    {frame_valid_in, line_valid_in} = 2'b01;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'hf;
    pkt_type = 6'h00;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk({sensors_enabled, sensor_gain_apply, voltage_gain_ratio}, 10'h304);
    for (int i = 0; i < 9; i++)
      rd(10'h010 + 10'(i), rst_tab[i]);
    apb(1'b0, 10'h019, 8'h00);
    chk({re, rq}, 9'h100);
    wr(10'h011, 8'h25);
    wr(10'h010, 8'h08);
    pkt(6'h25, 1'b1);
    pkt(6'h26, 1'b0);
    @(posedge pclk) fast_video_mode <= 1'b1;
    pkt(6'h25, 1'b1);
    wr(10'h011, 8'h2a);
    rd(10'h011, 8'h25);
    wr(10'h010, 8'h00);
    wr(10'h011, 8'h0a);
    wr(10'h010, 8'h08);
    pkt(6'h0a, 1'b0);
    wr(10'h010, 8'h10);
    pkt(6'h12, 1'b1);
    pkt(6'h05, 1'b0);
    wr(10'h010, 8'h04);
    pkt(6'h19, 1'b1);
    pkt(6'h1d, 1'b1);
    pkt(6'h1f, 1'b1);
    @(posedge pclk) fast_video_mode <= 1'b0;
    pkt(6'h19, 1'b0);
    wr(10'h010, 8'h03);
    settle();
    chk({frame_valid_out, line_valid_out}, 2'b10);
    wr(10'h010, 8'h02);
    settle();
    chk({frame_valid_out, line_valid_out}, 2'b11);
    wr(10'h013, 8'h83);
    #1;
    chk(parity_inject_busy, 1'b1);
    pulses(3);
    chk(parity_inject_busy, 1'b0);
    rd(10'h013, 8'h03);
    wr(10'h014, 8'h08);
    #1;
    chk(self_test_active, 1'b1);
    pulses(3);
    wr(10'h013, 8'h82);
    pulses(0);
    wr(10'h014, 8'h0a);
    #1;
    chk(self_test_clock_select, clk_int_50m);
    wr(10'h014, 8'h0c);
    #1;
    chk(self_test_clock_select, clk_int_25m);
    wr(10'h014, 8'h0e);
    #1;
    chk(self_test_clock_select, clk_int_25m);
    wr(10'h014, 8'h00);
    #1;
    chk({self_test_active, self_test_clock_select}, 3'b000);
    wr(10'h014, 8'h01);
    #1;
    chk({remote_self_test_enable, self_test_active}, 2'b11);
    wr(10'h014, 8'h10);
    #1;
    chk(forward_error_force_enable, 1'b1);
    wr(10'h014, 8'h00);
    #1;
    chk(forward_error_force_enable, 1'b0);
    wr(10'h015, 8'h40);
    settle();
    chk({voltage_gain_divisor, voltage_gain_ratio}, 15'h4002);
    wr(10'h015, 8'h10);
    settle();
    chk(voltage_gain_ratio, 8'h08);
    wr(10'h017, 8'h30);
    #1;
    chk({sensors_enabled, gpio_sense_select}, 3'b000);
    wr(10'h017, 8'h3d);
    #1;
    chk({sensors_enabled, gpio_sense_select}, 3'b101);
    wr(10'h017, 8'h3e);
    #1;
    chk(gpio_sense_select, 2'b10);
    wr(10'h016, 8'h18);
    rd(10'h016, 8'h18);
    wr(10'h018, 8'h00);
    #1;
    chk(sensor_gain_apply, 1'b0);
    rd(10'h018, 8'h00);
    print_verdict();
  end

  // Tests need well under 2000 cycles; a hang ends the run here
  initial
  begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    print_verdict();
  end
endmodule
